// file: core/ssdl_consts.vh
`ifndef SSDL_CONSTS_VH
`define SSDL_CONSTS_VH

// setup word layout
`define SSDL_SETUP_W 16
`define SSDL_SETUP_RST 16'h0020
`define SSDL_SETUP_WMASK 16'h733F
`define SSDL_RANGE_HI 14
`define SSDL_RANGE_LO 12
`define SSDL_SHORT_HI 9
`define SSDL_SHORT_LO 8
`define SSDL_FUNC_BIT 5
`define SSDL_COMM_BIT 4
`define SSDL_OVDIS_BIT 3
`define SSDL_LATCH_BIT 2
`define SSDL_NOFORCE_BIT 1
`define SSDL_LOCK_BIT 0

// short detection modes
`define SSDL_SHORT_OFF 2'h0
`define SSDL_SHORT_SUP 2'h1
`define SSDL_SHORT_GND 2'h2
`define SSDL_SHORT_TRI 2'h3

// output selections
`define SSDL_OUT_NORMAL 2'h0
`define SSDL_OUT_UPPER 2'h1
`define SSDL_OUT_GROUND 2'h2
`define SSDL_OUT_TRI 2'h3

// output codes for the forced levels
`define SSDL_CODE_UPPER 16'h7FFF
`define SSDL_CODE_GROUND 16'h0000

// diagnosis flag positions
`define SSDL_FLAGS_W 11
`define SSDL_FL_WBSUP 0
`define SSDL_FL_WBGND 1
`define SSDL_FL_UV 2
`define SSDL_FL_OT 3
`define SSDL_FL_OV 4
`define SSDL_FL_EEP 5
`define SSDL_FL_ROM 6
`define SSDL_FL_FSM 7
`define SSDL_FL_ADD 8
`define SSDL_FL_OCHI 9
`define SSDL_FL_OCLO 10

// signal path
`define SSDL_FILT_W 22
`define SSDL_MAX_RANGE 3'h6
`define SSDL_LIN_MAX 16'h7FFF
`define SSDL_SEG_BITS 4
`define SSDL_FRAC_BITS 11
`define SSDL_GAIN_SHIFT 15

`endif

// file: core/ssdl_range_shift.v
`timescale 1ns/100ps
`include "ssdl_consts.vh"

module ssdl_range_shift (
  input wire ref_clk,
  input wire reset,
  input wire sampleValid,
  input wire [21:0] filtIn,
  input wire [2:0] rangeSel,
  output reg [15:0] shiftOut_r,
  output reg shiftValid_r
);

  // ---------------------------------------------------------------
  // window select and clamp
  // ---------------------------------------------------------------
  reg [2:0] rangeEff;
  reg [4:0] shAmt;
  reg signed [28:0] wide;
  reg signed [28:0] shifted;

  // setting s keeps bits (22-s)..(7-s); 7 is not defined, treated as 6
  always @* begin
    rangeEff = (rangeSel > `SSDL_MAX_RANGE) ? `SSDL_MAX_RANGE : rangeSel;
    shAmt = 5'd7 - {2'b00, rangeEff};
    wide = {{7{filtIn[21]}}, filtIn};
    shifted = wide >>> shAmt;
  end

  // out-of-range fields clamp to the 16-bit limits instead of wrapping
  always @(posedge ref_clk) begin
    if (reset) begin
      shiftOut_r <= 16'h0000;
      shiftValid_r <= 1'b0;
    end else begin
      shiftValid_r <= sampleValid;
      if (sampleValid) begin
        if (shifted > 29'sd32767)
          shiftOut_r <= 16'h7FFF;
        else if (shifted < -29'sd32768)
          shiftOut_r <= 16'h8000;
        else
          shiftOut_r <= shifted[15:0];
      end
    end
  end

endmodule // ssdl_range_shift

// file: core/ssdl_linearizer.v
`timescale 1ns/100ps
`include "ssdl_consts.vh"

module ssdl_linearizer #(
  parameter SEGMENTS = 16
) (
  input wire ref_clk,
  input wire reset,
  input wire inValid,
  input wire [14:0] linIn,
  input wire spWrEn,
  input wire [3:0] spWrIdx,
  input wire [15:0] spWrData,
  output reg [15:0] linOut_r,
  output reg linValid_r
);

  // ---------------------------------------------------------------
  // setpoint store
  // ---------------------------------------------------------------
  reg [15:0] linearizationSetpoint [0:SEGMENTS-1];
  integer i;

  // setpoints are offsets from the straight line, so zeros are neutral
  always @(posedge ref_clk) begin
    if (reset) begin
      for (i = 0; i < SEGMENTS; i = i + 1)
        linearizationSetpoint[i] <= 16'h0000;
    end else if (spWrEn) begin
      linearizationSetpoint[spWrIdx] <= spWrData;
    end
  end

  // ---------------------------------------------------------------
  // segment interpolation
  // ---------------------------------------------------------------
  reg [3:0] seg;
  reg [10:0] frac;
  reg signed [16:0] loPt;
  reg signed [16:0] hiPt;
  reg signed [17:0] span;
  reg signed [29:0] prod;
  reg signed [19:0] sum;

  // left edge of segment 0 is anchored at offset zero
  always @*
  begin
    seg = linIn[14:11];
    frac = linIn[10:0];
    loPt = (seg == 4'h0) ? 17'sd0 : {linearizationSetpoint[seg - 4'h1][15], linearizationSetpoint[seg - 4'h1]};
    hiPt = {linearizationSetpoint[seg][15], linearizationSetpoint[seg]};
    span = {hiPt[16], hiPt} - {loPt[16], loPt};
    prod = span * $signed({1'b0, frac});
    // the scaled product keeps its sign, so falling segments pull the sum down
    sum = $signed({5'b00000, linIn}) + {{3{loPt[16]}}, loPt}
      + {prod[29], prod[29:11]};
  end

  // result is held to the non-negative range of the next stage
  always @(posedge ref_clk) begin
    if (reset) begin
      linOut_r <= 16'h0000;
      linValid_r <= 1'b0;
    end else begin
      linValid_r <= inValid;
      if (inValid) begin
        if (sum < 20'sd0)
          linOut_r <= 16'h0000;
        else if (sum > 20'sd32767)
          linOut_r <= `SSDL_LIN_MAX;
        else
          linOut_r <= sum[15:0];
      end
    end
  end

endmodule // ssdl_linearizer

// file: core/ssdl_top.v
`timescale 1ns/100ps
`include "ssdl_consts.vh"

module ssdl_top (
  input wire ref_clk,
  input wire reset,
  input wire setupWrEn,
  input wire [15:0] setupWrData,
  input wire spWrEn,
  input wire [3:0] spWrIdx,
  input wire [15:0] spWrData,
  input wire [15:0] scaleGain,
  input wire [15:0] scaleOffset,
  input wire sampleValid,
  input wire [21:0] filtIn,
  input wire supplyWireBreak,
  input wire groundWireBreak,
  input wire underVoltage,
  input wire overTemp,
  input wire overVoltage,
  input wire eepromSelfTestFail,
  input wire romParityFail,
  input wire fsmSelfTestFail,
  input wire adderOverflow,
  input wire highSideOverCurrent,
  input wire lowSideOverCurrent,
  output wire [15:0] customerSetupWord,
  output wire memLocked,
  output wire outputPinCommunication,
  output wire functionNormal,
  output wire setupWrRefused,
  output reg [10:0] diagFlags_r,
  output reg [1:0] outSel_r,
  output reg [15:0] outCode_r,
  output reg outOeN_r,
  output reg outValid_r
);

  // ---------------------------------------------------------------
  // customer setup word
  // ---------------------------------------------------------------
  reg [15:0] customerSetupWord_r;
  reg [15:0] setupNxt;
  wire lockNow;

  // once locked the memory image is frozen until the next reset
  assign lockNow = customerSetupWord_r[`SSDL_LOCK_BIT];

  // reserved bits are masked so they always read zero
  always @* begin
    setupNxt = customerSetupWord_r;
    if (setupWrEn && !lockNow)
      setupNxt = setupWrData & `SSDL_SETUP_WMASK;
  end

  always @(posedge ref_clk) begin
    if (reset)
      customerSetupWord_r <= `SSDL_SETUP_RST;
    else
      customerSetupWord_r <= setupNxt;
  end

  assign customerSetupWord = customerSetupWord_r;
  assign memLocked = lockNow;
  assign setupWrRefused = (setupWrEn | spWrEn) & lockNow;
  assign outputPinCommunication = customerSetupWord_r[`SSDL_COMM_BIT];
  assign functionNormal = customerSetupWord_r[`SSDL_FUNC_BIT];

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  wire [2:0] rangeSel;
  wire [1:0] shortMode;
  wire ovActive;
  wire latchOn;
  wire forceOn;

  assign rangeSel = customerSetupWord_r[`SSDL_RANGE_HI:`SSDL_RANGE_LO];
  assign shortMode = customerSetupWord_r[`SSDL_SHORT_HI:`SSDL_SHORT_LO];
  assign ovActive = ~customerSetupWord_r[`SSDL_OVDIS_BIT];
  assign latchOn = customerSetupWord_r[`SSDL_LATCH_BIT];
  assign forceOn = ~customerSetupWord_r[`SSDL_NOFORCE_BIT];

  // ---------------------------------------------------------------
  // diagnosis input synchronisers
  // ---------------------------------------------------------------
  // analog monitors are asynchronous to ref_clk, two flops each
  wire [10:0] diagRaw;
  reg [10:0] diagMeta_r;
  reg [10:0] diagSync_r;

  assign diagRaw = {lowSideOverCurrent, highSideOverCurrent, adderOverflow,
    fsmSelfTestFail, romParityFail, eepromSelfTestFail, overVoltage,
    overTemp, underVoltage, groundWireBreak, supplyWireBreak};

  always @(posedge ref_clk) begin
    if (reset) begin
      diagMeta_r <= 11'h000;
      diagSync_r <= 11'h000;
    end else begin
      diagMeta_r <= diagRaw;
      diagSync_r <= diagMeta_r;
    end
  end

  // ---------------------------------------------------------------
  // qualified faults
  // ---------------------------------------------------------------
  reg [10:0] liveFault;
  wire shortDetOn;

  assign shortDetOn = (shortMode != `SSDL_SHORT_OFF);

  // monitors that are disabled never raise a flag
  always @* begin
    liveFault = diagSync_r;
    liveFault[`SSDL_FL_OV] = diagSync_r[`SSDL_FL_OV] & ovActive;
    liveFault[`SSDL_FL_OCHI] = diagSync_r[`SSDL_FL_OCHI] & shortDetOn
      & (shortMode != `SSDL_SHORT_TRI);
    liveFault[`SSDL_FL_OCLO] = diagSync_r[`SSDL_FL_OCLO] & shortDetOn;
  end

  // ---------------------------------------------------------------
  // diagnosis flags
  // ---------------------------------------------------------------
  reg [10:0] diagFlagsNxt;

  // latched mode: a flag once set is held until reset, new faults add in
  always @* begin
    if (latchOn)
      diagFlagsNxt = diagFlags_r | liveFault;
    else
      diagFlagsNxt = liveFault;
  end

  always @(posedge ref_clk) begin
    if (reset)
      diagFlags_r <= 11'h000;
    else
      diagFlags_r <= diagFlagsNxt;
  end

  // ---------------------------------------------------------------
  // fault classes
  // ---------------------------------------------------------------
  wire alwaysFault;
  wire custFault;
  wire ocSup;
  wire ocGnd;
  wire ocTri;

  // always-on group acts regardless of the setup word
  assign alwaysFault = diagFlagsNxt[`SSDL_FL_WBGND] | diagFlagsNxt[`SSDL_FL_UV];
  // customer group only acts when the force bit allows it
  assign custFault = forceOn & (diagFlagsNxt[`SSDL_FL_OV] | diagFlagsNxt[`SSDL_FL_EEP]
    | diagFlagsNxt[`SSDL_FL_ROM] | diagFlagsNxt[`SSDL_FL_FSM]
    | diagFlagsNxt[`SSDL_FL_ADD]);
  assign ocSup = (shortMode == `SSDL_SHORT_SUP) &
    (diagFlagsNxt[`SSDL_FL_OCHI] | diagFlagsNxt[`SSDL_FL_OCLO]);
  assign ocGnd = (shortMode == `SSDL_SHORT_GND) &
    (diagFlagsNxt[`SSDL_FL_OCHI] | diagFlagsNxt[`SSDL_FL_OCLO]);
  assign ocTri = (shortMode == `SSDL_SHORT_TRI) & diagFlagsNxt[`SSDL_FL_OCLO];

  // ---------------------------------------------------------------
  // range shifter
  // ---------------------------------------------------------------
  wire [15:0] shiftOut;
  wire shiftValid;

  ssdl_range_shift u_shift (
    .ref_clk(ref_clk),
    .reset(reset),
    .sampleValid(sampleValid),
    .filtIn(filtIn),
    .rangeSel(rangeSel),
    .shiftOut_r(shiftOut),
    .shiftValid_r(shiftValid)
  );

  // ---------------------------------------------------------------
  // gain and offset scaling
  // ---------------------------------------------------------------
  reg signed [31:0] scaleProd;
  reg signed [17:0] scaleSum;
  reg [14:0] scaled_r;
  reg scaledValid_r;

  // gain is a signed fraction of 2^15
  always @* begin
    scaleProd = $signed(shiftOut) * $signed(scaleGain);
    scaleSum = {scaleProd[31], scaleProd[31:15]} + {{2{scaleOffset[15]}}, scaleOffset};
  end

  // negative results clamp to zero, the linearizer takes no sign
  always @(posedge ref_clk) begin
    if (reset) begin
      scaled_r <= 15'h0000;
      scaledValid_r <= 1'b0;
    end else begin
      scaledValid_r <= shiftValid;
      if (shiftValid) begin
        if (scaleSum < 18'sd0)
          scaled_r <= 15'h0000;
        else if (scaleSum > 18'sd32767)
          scaled_r <= 15'h7FFF;
        else
          scaled_r <= scaleSum[14:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // setpoint linearizer
  // ---------------------------------------------------------------
  wire [15:0] linOut;
  wire linValid;
  wire spWrOk;

  // locked memory refuses setpoint writes as well
  assign spWrOk = spWrEn & ~lockNow;

  ssdl_linearizer #(
    .SEGMENTS(16)
  ) u_lin (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(scaledValid_r),
    .linIn(scaled_r),
    .spWrEn(spWrOk),
    .spWrIdx(spWrIdx),
    .spWrData(spWrData),
    .linOut_r(linOut),
    .linValid_r(linValid)
  );

  // ---------------------------------------------------------------
  // output selection
  // ---------------------------------------------------------------
  reg [1:0] outSelNxt;

  // priority: thermal, supply break, short action, diagnosis, signal
  always @* begin
    if (diagFlagsNxt[`SSDL_FL_OT])
      outSelNxt = `SSDL_OUT_TRI;
    else if (diagFlagsNxt[`SSDL_FL_WBSUP])
      outSelNxt = `SSDL_OUT_GROUND;
    else if (ocTri)
      outSelNxt = `SSDL_OUT_TRI;
    else if (ocGnd)
      outSelNxt = `SSDL_OUT_GROUND;
    else if (ocSup | alwaysFault | custFault)
      outSelNxt = `SSDL_OUT_UPPER;
    else
      outSelNxt = `SSDL_OUT_NORMAL;
  end

  // fault levels take over the very next edge, not the next sample
  always @(posedge ref_clk) begin
    if (reset) begin
      outSel_r <= `SSDL_OUT_NORMAL;
      outCode_r <= 16'h0000;
      outOeN_r <= 1'b0;
      outValid_r <= 1'b0;
    end else begin
      outSel_r <= outSelNxt;
      outOeN_r <= (outSelNxt == `SSDL_OUT_TRI);
      outValid_r <= linValid | (outSelNxt != outSel_r);
      case (outSelNxt)
        `SSDL_OUT_UPPER: begin
          outCode_r <= `SSDL_CODE_UPPER;
        end
        `SSDL_OUT_GROUND: begin
          outCode_r <= `SSDL_CODE_GROUND;
        end
        `SSDL_OUT_TRI: begin
          outCode_r <= `SSDL_CODE_GROUND;
        end
        `SSDL_OUT_NORMAL: begin
          if (linValid)
            outCode_r <= linOut;
          else if (outSel_r != `SSDL_OUT_NORMAL)
            outCode_r <= linOut;
        end
        default: begin
          outCode_r <= `SSDL_CODE_GROUND;
        end
      endcase
    end
  end

endmodule // ssdl_top

// file: verif/ssdl_top_sva.sv
`timescale 1ns/100ps
// ----------------------------------------
// setup decode and diagnosis checker
// ----------------------------------------
module ssdl_top_sva (
  input wire ref_clk,
  input wire reset,
  input wire setupWrEn,
  input wire [15:0] setupWrData,
  input wire sampleValid,
  input wire underVoltage,
  input wire [15:0] customerSetupWord,
  input wire memLocked,
  input wire outputPinCommunication,
  input wire setupWrRefused,
  input wire [10:0] diagFlags_r,
  input wire [1:0] outSel_r,
  input wire [15:0] outCode_r,
  input wire outOeN_r,
  input wire outValid_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // a sample that meets no fault while it walks the four stages
  sequence s_quiet_in;
    sampleValid && diagFlags_r == 11'h000;
  endsequence
  sequence s_quiet_run;
    s_quiet_in ##1 (diagFlags_r == 11'h000) [*3];
  endsequence
  a_setup_write: assert property (setupWrEn && !memLocked |=> customerSetupWord == ($past(setupWrData) & 16'h733F))
    else $error("setup write not taken");
  a_lock_refuse: assert property (setupWrEn && memLocked |-> setupWrRefused ##1 $stable(customerSetupWord))
    else $error("locked setup write not refused");
  a_decode_follows: assert property (outputPinCommunication == customerSetupWord[4] && memLocked == customerSetupWord[0])
    else $error("decoded bits differ from setup word");
  a_latch_hold: assert property (customerSetupWord[2] |=> (diagFlags_r & $past(diagFlags_r)) == $past(diagFlags_r))
    else $error("latched flag dropped");
  a_uv_flag: assert property (underVoltage [*3] |=> diagFlags_r[2])
    else $error("undervoltage flag missing");
  a_force_upper: assert property (diagFlags_r[3:0] == 4'h0 && diagFlags_r[10:9] == 2'h0 && (|diagFlags_r[8:4])
    && !customerSetupWord[1] && $stable(customerSetupWord) |-> outSel_r == 2'h1 && outCode_r == 16'h7FFF)
    else $error("customer fault did not force upper level");
  a_overtemp_tri: assert property (diagFlags_r[3] |-> outSel_r == 2'h3 && outOeN_r)
    else $error("overtemperature not tristate");
  a_supply_ground: assert property (diagFlags_r[0] && !diagFlags_r[3] |-> outSel_r == 2'h2 && !outOeN_r)
    else $error("supply break not grounded");
  a_sample_latency: assert property (s_quiet_run |=> outValid_r)
    else $error("sample answer late");
endmodule // ssdl_top_sva

bind ssdl_top ssdl_top_sva u_sva (.ref_clk(ref_clk), .reset(reset), .setupWrEn(setupWrEn),
  .setupWrData(setupWrData), .sampleValid(sampleValid), .underVoltage(underVoltage),
  .customerSetupWord(customerSetupWord), .memLocked(memLocked), .outputPinCommunication(outputPinCommunication),
  .setupWrRefused(setupWrRefused), .diagFlags_r(diagFlags_r), .outSel_r(outSel_r), .outCode_r(outCode_r),
  .outOeN_r(outOeN_r), .outValid_r(outValid_r));

// file: verif/ssdl_prog_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// programmer on the output pin
// ----------------------------------------
module ssdl_prog_model (
  input wire ref_clk,
  input wire setupWrRefused,
  output reg setupWrEn,
  output reg [15:0] setupWrData,
  output reg spWrEn,
  output reg [3:0] spWrIdx,
  output reg [15:0] spWrData,
  output reg sawRefused
);
  // idle bus; data lines carry junk, never a stale value
  initial begin
    setupWrEn = 1'b0;
    spWrEn = 1'b0;
    setupWrData = 16'hA5A5;
    spWrIdx = 4'h0;
    spWrData = 16'h5A5A;
    sawRefused = 1'b0;
  end
  // one-cycle strobe; bit0 set by caller only when locking on purpose
  task write_setup(input [15:0] d);
    begin
      setupWrEn = 1'b1;
      setupWrData = d;
      #1 sawRefused = setupWrRefused;
      @(posedge ref_clk);
      #1 setupWrEn = 1'b0;
      setupWrData = ~d;
      // idle edge so a following call never re-raises the strobe in one step
      @(posedge ref_clk);
      #1;
    end
  endtask
  // callers set setpoint 0 only, the one write to setpoint 1 is made while locked and refused; segment 1 falls back and the rest stay flat
  task write_sp(input [3:0] i, input [15:0] d);
    begin
      spWrEn = 1'b1;
      spWrIdx = i;
      spWrData = d;
      #1 sawRefused = setupWrRefused;
      @(posedge ref_clk);
      #1 spWrEn = 1'b0;
      spWrData = ~d;
      @(posedge ref_clk);
      #1;
    end
  endtask
endmodule // ssdl_prog_model

// file: verif/tb_sensor_setup_diag_linearizer.sv
`timescale 1ns/100ps
// ----------------------------------------
// bench for setup, diagnosis and linearizer
// ----------------------------------------
module tb_sensor_setup_diag_linearizer;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg sampleValid = 1'b0;
  reg [21:0] filtIn = 22'h000000;
  reg [15:0] scaleGain = 16'h4000;
  reg [15:0] scaleOffset = 16'h0000;
  reg [10:0] faults = 11'h000;
  wire setupWrEn, spWrEn, setupWrRefused, memLocked, outputPinCommunication, outOeN_r, outValid_r, sawRefused;
  wire functionNormal;
  wire [15:0] setupWrData, spWrData, customerSetupWord, outCode_r;
  wire [3:0] spWrIdx;
  wire [10:0] diagFlags_r;
  wire [1:0] outSel_r;
  integer failures = 0;
  integer num_checks = 0;
  // 200 MHz
  always #2.5 ref_clk = ~ref_clk;
  ssdl_top dut_u (.ref_clk(ref_clk), .reset(reset), .setupWrEn(setupWrEn), .setupWrData(setupWrData),
    .spWrEn(spWrEn), .spWrIdx(spWrIdx), .spWrData(spWrData), .scaleGain(scaleGain), .scaleOffset(scaleOffset),
    .sampleValid(sampleValid), .filtIn(filtIn), .supplyWireBreak(faults[0]), .groundWireBreak(faults[1]),
    .underVoltage(faults[2]), .overTemp(faults[3]), .overVoltage(faults[4]), .eepromSelfTestFail(faults[5]),
    .romParityFail(faults[6]), .fsmSelfTestFail(faults[7]), .adderOverflow(faults[8]),
    .highSideOverCurrent(faults[9]), .lowSideOverCurrent(faults[10]), .customerSetupWord(customerSetupWord),
    .memLocked(memLocked), .outputPinCommunication(outputPinCommunication), .functionNormal(functionNormal),
    .setupWrRefused(setupWrRefused), .diagFlags_r(diagFlags_r), .outSel_r(outSel_r), .outCode_r(outCode_r),
    .outOeN_r(outOeN_r), .outValid_r(outValid_r));
  ssdl_prog_model prog_u (.ref_clk(ref_clk), .setupWrRefused(setupWrRefused), .setupWrEn(setupWrEn),
    .setupWrData(setupWrData), .spWrEn(spWrEn), .spWrIdx(spWrIdx), .spWrData(spWrData), .sawRefused(sawRefused));
  // inputs always move 1 ns after the edge
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task chk(input [8*10-1:0] what, input [15:0] exp, input [15:0] seen);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task do_reset;
    begin
      reset = 1'b1;
      tick(6);
      reset = 1'b0;
    end
  endtask
  // one sample; answer waited for under a bound
  task sample(input [21:0] f, input [15:0] exp);
    integer i;
    begin
      filtIn = f;
      sampleValid = 1'b1;
      tick(1);
      sampleValid = 1'b0;
      filtIn = ~f;
      for (i = 0; i < 8 && outValid_r !== 1'b1; i = i + 1) tick(1);
      chk("outValid", 16'h0001, {15'h0000, outValid_r});
      chk("outCode", exp, outCode_r);
    end
  endtask
  // raise one fault, judge the output, drop it and see recovery
  task fault_case(input integer b, input [15:0] setup, input [1:0] sel, input fl);
    begin
      prog_u.write_setup(setup);
      faults[b] = 1'b1;
      tick(5);
      chk("flag", {15'h0000, fl}, {15'h0000, diagFlags_r[b]});
      chk("outSel", {14'h0000, sel}, {14'h0000, outSel_r});
      chk("outOeN", {15'h0000, sel == 2'h3}, {15'h0000, outOeN_r});
      if (sel != 2'h0) chk("outCode", (sel == 2'h1) ? 16'h7FFF : 16'h0000, outCode_r);
      faults[b] = 1'b0;
      tick(5);
      chk("outSel", 16'h0000, {14'h0000, outSel_r});
    end
  endtask
  // watchdog, far beyond the expected few hundred cycles
  initial begin
    #20000;
    failures = failures + 1;
    summarize;
  end
  // main sequence
  initial begin
    do_reset;
    chk("setup", 16'h0020, customerSetupWord);
    chk("flags", 16'h0000, {5'h00, diagFlags_r});
    chk("func", 16'h0001, {15'h0000, functionNormal});
    prog_u.write_setup(16'hFFFE);
    chk("setup", 16'h733E, customerSetupWord);
    chk("comm", 16'h0001, {15'h0000, outputPinCommunication});
    prog_u.write_setup(16'h0020);
    chk("comm", 16'h0000, {15'h0000, outputPinCommunication});
    sample(22'h004000, 16'h0040);
    prog_u.write_setup(16'h6020);
    sample(22'h004000, 16'h1000);
    prog_u.write_setup(16'h0020);
    // quarter gain: 128 from the shifter scales to 32
    scaleGain = 16'h2000;
    sample(22'h004000, 16'h0020);
    scaleGain = 16'h4000;
    scaleOffset = 16'h0400;
    sample(22'h000000, 16'h0400);
    prog_u.write_sp(4'h0, 16'h0100);
    sample(22'h000000, 16'h0480);
    scaleOffset = 16'h0800;
    sample(22'h000000, 16'h0900);
    // falling segment mid-way: 3072 + 256 - 128
    scaleOffset = 16'h0C00;
    sample(22'h000000, 16'h0C80);
    scaleOffset = 16'h8000;
    sample(22'h000000, 16'h0000);
    scaleOffset = 16'h0000;
    fault_case(0, 16'h0020, 2'h2, 1'b1);
    fault_case(3, 16'h0020, 2'h3, 1'b1);
    fault_case(2, 16'h0020, 2'h1, 1'b1);
    fault_case(1, 16'h0022, 2'h1, 1'b1);
    fault_case(4, 16'h0020, 2'h1, 1'b1);
    fault_case(4, 16'h0028, 2'h0, 1'b0);
    fault_case(5, 16'h0020, 2'h1, 1'b1);
    fault_case(6, 16'h0020, 2'h1, 1'b1);
    fault_case(7, 16'h0020, 2'h1, 1'b1);
    fault_case(8, 16'h0020, 2'h1, 1'b1);
    fault_case(8, 16'h0022, 2'h0, 1'b1);
    fault_case(9, 16'h0120, 2'h1, 1'b1);
    fault_case(9, 16'h0220, 2'h2, 1'b1);
    fault_case(10, 16'h0020, 2'h0, 1'b0);
    fault_case(10, 16'h0320, 2'h3, 1'b1);
    fault_case(9, 16'h0320, 2'h0, 1'b0);
    prog_u.write_setup(16'h0024);
    faults[2] = 1'b1;
    tick(5);
    faults[2] = 1'b0;
    tick(8);
    chk("flag", 16'h0004, {5'h00, diagFlags_r});
    chk("outSel", 16'h0001, {14'h0000, outSel_r});
    do_reset;
    chk("flags", 16'h0000, {5'h00, diagFlags_r});
    prog_u.write_setup(16'h0021);
    chk("locked", 16'h0001, {15'h0000, memLocked});
    prog_u.write_setup(16'h0000);
    chk("refused", 16'h0001, {15'h0000, sawRefused});
    chk("setup", 16'h0021, customerSetupWord);
    prog_u.write_sp(4'h1, 16'h0200);
    chk("refused", 16'h0001, {15'h0000, sawRefused});
    // refused setpoint must leave the straight line untouched
    scaleOffset = 16'h0C00;
    sample(22'h000000, 16'h0C00);
    summarize;
  end
endmodule // tb_sensor_setup_diag_linearizer
